// file: prot_switch_params.svh
// register offsets, reset values and timing counts of the protection switch block
`ifndef PROT_SWITCH_PARAMS_SVH
`define PROT_SWITCH_PARAMS_SVH
`define OFS_SWITCH_CFG 12'h000
`define OFS_DEBOUNCE 12'h004
`define OFS_PROT_EN_A 12'h008
`define OFS_COMMAND 12'h00C
`define OFS_STATE 12'h010
`define OFS_SAFETY 12'h014
`define OFS_IRQ_STATUS 12'h018
`define OFS_IRQ_MASK 12'h01C
`define BIT_RECOVERY_ALLOW 0
`define BIT_AUTO_DEFAULT 2
`define BIT_SERIES_MODE 3
`define BIT_IDLE_HOLD 4
`define BIT_ON_ALLOW 5
`define BIT_OFF_ALLOW 6
`define BIT_DETECT_EN 7
`define RST_SWITCH_CFG 8'h18
`define RST_DEBOUNCE 8'h01
`define RST_PROT_EN_A 8'hA1
`define STEP_MS 100
`define CLK_KHZ 10000
`define STEP_CYCLES (`STEP_MS * `CLK_KHZ)
`endif

// file: prot_switch_pkg.sv
// types of the protection switch block
package prot_switch_pkg;
   typedef enum logic [3:0] {
      cmd_none = 4'h0,
      cmd_auto_toggle = 4'h1,
      cmd_chg_off = 4'h2,
      cmd_chg_on = 4'h3,
      cmd_dsg_off = 4'h4,
      cmd_dsg_on = 4'h5,
      cmd_recover = 4'h6,
      cmd_edit_enter = 4'h7,
      cmd_edit_exit = 4'h8
   } cmd_code_t;
   typedef enum logic [1:0] {
      st_run = 2'b01,
      st_edit = 2'b10
   } mode_t;
   typedef struct packed {
      logic chg;
      logic dsg;
   } switch_pair_t;
endpackage : prot_switch_pkg

// file: protection_switch_config.sv
// register bank and switch control of the battery protection switches
//
// Function
// - idle-hold 0 turns charge switch off at low current
// - body-diode protection re-enables charge switch
// - series mode setting enables body-diode protection
// - series mode: body-diode current turns switch on
// - stored autonomous default loaded on edit exit
// - active autonomous state reported, host toggles it
// - test mode: switches on only by command or body-diode current
// - body-diode protection still works in test mode
// - autonomous mode accepts commands, gated by allows
// - recovery in locked state needs permission bit
// - debounce count in 100 ms steps, default 1
// - safety flag set only when protection enabled
// - switch masks, not enables, choose switch action
// - enable mask bit map, reset 0xA1
// - switch-off and switch-on allows gate host commands
// - charge detector runs only when enabled
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "prot_switch_params.svh"

module protection_switch_config
   import prot_switch_pkg::*;
#(
   parameter int STEP_CYCLES = `STEP_CYCLES
) (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pack conditions
   input wire logic current_low,
   input wire switch_pair_t body_diode_current,
   input wire logic [7:0] fault_detect_a,
   input wire switch_pair_t fault_switch_off,
   input wire logic locked_security_state,
   input wire logic charge_detect_raw,
   // switch drivers and status
   output switch_pair_t switch_drive,
   output logic charge_detect_filtered,
   output logic recovery_pulse,
   output logic irq
);

   // refused at elaboration: a zero step would never close a debounce period
   if (STEP_CYCLES < 1) begin : g_step_check
      $error("STEP_CYCLES must be at least one");
   end

   // ==========================================================
   // register state
   logic [7:0] switch_cfg;
   logic [7:0] charge_detect_debounce;
   logic [7:0] protection_enable_a;
   logic [7:0] safety_status_a;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic autonomous_switch_ctrl;
   switch_pair_t host_cmd_on;
   mode_t mode;
   logic wr;
   logic rd;
   logic cmd_wr;
   cmd_code_t cmd;
   logic recover_ok;
   logic recover_bad;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   assign wr = psel && penable && pwrite && pready;
   assign rd = psel && !penable && !pwrite;
   assign cmd_wr = wr && hit(paddr, `OFS_COMMAND);
   assign cmd = cmd_code_t'(pwdata[3:0]);
   assign recover_ok = cmd_wr && (cmd == cmd_recover)
      && (!locked_security_state || switch_cfg[`BIT_RECOVERY_ALLOW]);
   assign recover_bad = cmd_wr && (cmd == cmd_recover) && !recover_ok;

   // ==========================================================
   // apb handshake: no wait state, answer in access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (rd) begin
            case (paddr)
               `OFS_SWITCH_CFG: prdata <= {24'h000000, switch_cfg};
               `OFS_DEBOUNCE: prdata <= {24'h000000, charge_detect_debounce};
               `OFS_PROT_EN_A: prdata <= {24'h000000, protection_enable_a};
               `OFS_COMMAND: prdata <= 32'h0000_0000;
               `OFS_STATE: prdata <= {27'h0, charge_detect_filtered, mode == st_edit,
                  autonomous_switch_ctrl, switch_drive.chg, switch_drive.dsg};
               `OFS_SAFETY: prdata <= {24'h000000, safety_status_a};
               `OFS_IRQ_STATUS: prdata <= {30'h0, irq_status};
               `OFS_IRQ_MASK: prdata <= {30'h0, irq_mask};
               default: pslverr <= 1'b1;
            endcase
         end else if (!(hit(paddr, `OFS_SWITCH_CFG) || hit(paddr, `OFS_DEBOUNCE)
               || hit(paddr, `OFS_PROT_EN_A) || hit(paddr, `OFS_COMMAND)
               || hit(paddr, `OFS_SAFETY) || hit(paddr, `OFS_IRQ_STATUS)
               || hit(paddr, `OFS_IRQ_MASK))) begin
            pslverr <= 1'b1;
         end
      end
   end

   // ==========================================================
   // settings, writable only in edit mode so a live pack is not disturbed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         switch_cfg <= `RST_SWITCH_CFG;
         charge_detect_debounce <= `RST_DEBOUNCE;
         protection_enable_a <= `RST_PROT_EN_A;
      end else if (wr && mode == st_edit) begin
         if (hit(paddr, `OFS_SWITCH_CFG)) begin
            switch_cfg <= pwdata[7:0];
         end
         if (hit(paddr, `OFS_DEBOUNCE)) begin
            charge_detect_debounce <= pwdata[7:0];
         end
         if (hit(paddr, `OFS_PROT_EN_A)) begin
            protection_enable_a <= pwdata[7:0];
         end
      end
   end

   // ==========================================================
   // edit mode and autonomous control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= st_run;
      end else if (cmd_wr) begin
         case (mode)
            st_run: begin
               if (cmd == cmd_edit_enter) begin
                  mode <= st_edit;
               end
            end
            st_edit: begin
               if (cmd == cmd_edit_exit) begin
                  mode <= st_run;
               end
            end
            default: mode <= st_run;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         autonomous_switch_ctrl <= 1'b0;
      end else if (cmd_wr && mode == st_edit && cmd == cmd_edit_exit) begin
         autonomous_switch_ctrl <= switch_cfg[`BIT_AUTO_DEFAULT];
      end else if (cmd_wr && cmd == cmd_auto_toggle) begin
         autonomous_switch_ctrl <= !autonomous_switch_ctrl;
      end
   end

   // ==========================================================
   // host switch commands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_cmd_on <= '{chg: 1'b0, dsg: 1'b0};
      end else if (cmd_wr) begin
         // test mode obeys every command; autonomous mode checks the allows
         case (cmd)
            cmd_chg_on: begin
               if (!autonomous_switch_ctrl || switch_cfg[`BIT_ON_ALLOW]) begin
                  host_cmd_on.chg <= 1'b1;
               end
            end
            cmd_dsg_on: begin
               if (!autonomous_switch_ctrl || switch_cfg[`BIT_ON_ALLOW]) begin
                  host_cmd_on.dsg <= 1'b1;
               end
            end
            cmd_chg_off: begin
               if (!autonomous_switch_ctrl || switch_cfg[`BIT_OFF_ALLOW]) begin
                  host_cmd_on.chg <= 1'b0;
               end
            end
            cmd_dsg_off: begin
               if (!autonomous_switch_ctrl || switch_cfg[`BIT_OFF_ALLOW]) begin
                  host_cmd_on.dsg <= 1'b0;
               end
            end
            default: host_cmd_on <= host_cmd_on;
         endcase
      end
   end

   // ==========================================================
   // switch drivers
   switch_pair_t next_drive;
   logic host_forced_off_chg;
   logic host_forced_off_dsg;
   logic diode_en;
   assign host_forced_off_chg = autonomous_switch_ctrl && switch_cfg[`BIT_OFF_ALLOW] && !host_cmd_on.chg;
   assign host_forced_off_dsg = autonomous_switch_ctrl && switch_cfg[`BIT_OFF_ALLOW] && !host_cmd_on.dsg;
   assign diode_en = switch_cfg[`BIT_SERIES_MODE];

   always_comb begin
      if (autonomous_switch_ctrl) begin
         // masks decide the action, not the enables
         next_drive.chg = !fault_switch_off.chg && !host_forced_off_chg
            && !(current_low && !switch_cfg[`BIT_IDLE_HOLD]);
         next_drive.dsg = !fault_switch_off.dsg && !host_forced_off_dsg;
      end else begin
         next_drive = host_cmd_on;
      end
      // body-diode current overrides idle-off and test mode
      if (diode_en && body_diode_current.chg) begin
         next_drive.chg = 1'b1;
      end
      if (diode_en && body_diode_current.dsg) begin
         next_drive.dsg = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         switch_drive <= '{chg: 1'b0, dsg: 1'b0};
      end else begin
         switch_drive <= next_drive;
      end
   end

   // ==========================================================
   // safety flags; set wins over recovery clear
   logic [7:0] enabled_fault;
   logic [7:0] next_safety;
   assign enabled_fault = fault_detect_a & protection_enable_a;
   assign next_safety = (recover_ok ? 8'h00 : safety_status_a) | enabled_fault;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         safety_status_a <= 8'h00;
      end else begin
         safety_status_a <= next_safety;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         recovery_pulse <= 1'b0;
      end else begin
         recovery_pulse <= recover_ok;
      end
   end

   // ==========================================================
   // charge detect debounce
   logic [7:0] step_count;
   localparam int TICK_W = $clog2(STEP_CYCLES + 1);
   logic [TICK_W-1:0] tick_count;
   logic tick_done;
   logic detect_in;
   assign detect_in = charge_detect_raw && switch_cfg[`BIT_DETECT_EN];
   // raw input taken as synchronous to pclk; no synchroniser here
   assign tick_done = (tick_count == TICK_W'(STEP_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_count <= '0;
         step_count <= 8'h00;
         charge_detect_filtered <= 1'b0;
      end else if (!switch_cfg[`BIT_DETECT_EN]) begin
         tick_count <= '0;
         step_count <= 8'h00;
         charge_detect_filtered <= 1'b0;
      end else if (charge_detect_debounce == 8'h00) begin
         charge_detect_filtered <= detect_in;
      end else if (detect_in == charge_detect_filtered) begin
         // any bounce restarts the whole period
         tick_count <= '0;
         step_count <= 8'h00;
      end else if (tick_done) begin
         tick_count <= '0;
         if (step_count + 8'h01 >= charge_detect_debounce) begin
            step_count <= 8'h00;
            charge_detect_filtered <= detect_in;
         end else begin
            step_count <= step_count + 8'h01;
         end
      end else begin
         tick_count <= tick_count + 1'b1;
      end
   end

   // ==========================================================
   // interrupts: 0 safety fault, 1 recovery refused
   logic [1:0] irq_event;
   logic [1:0] irq_clear;
   logic [1:0] next_irq_status;
   assign irq_event = {recover_bad, |enabled_fault};
   assign irq_clear = (wr && hit(paddr, `OFS_IRQ_STATUS)) ? pwdata[1:0] : 2'b00;
   assign next_irq_status = (irq_status & ~irq_clear) | irq_event; // set wins over clear

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= 2'b00;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= 2'b00;
      end else if (wr && hit(paddr, `OFS_IRQ_MASK)) begin
         irq_mask <= pwdata[1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_irq_status & irq_mask);
      end
   end

endmodule : protection_switch_config

// file: prot_switch_checker_asserts.sv
// port-level assertion checker of the protection switch block
`timescale 1ns/1ps
module prot_switch_checker (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pack side
   input wire logic [7:0] fault_detect_a,
   input wire logic charge_detect_raw,
   input wire logic charge_detect_filtered,
   input wire logic recovery_pulse,
   input wire logic irq
);
   // ====
   // helpers
   logic setup;
   logic wr;
   logic rcv_cmd;
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite;
   assign rcv_cmd = wr && paddr == 12'h00C && pwdata[3:0] == 4'h6;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ====
   // bus
   property p_ready_after_setup;
      setup |=> pready;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
   property p_ready_single;
      pready |=> !pready;
   endproperty
   a_ready_single: assert property (p_ready_single) else $error("ready held too long");
   property p_unmapped;
      setup && paddr >= 12'h020 |=> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_prdata_hold;
      !psel && !pready |=> $stable(prdata);
   endproperty
   a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved while idle");
   // ====
   // detector, recovery, interrupt
   property p_filter_rise;
      $rose(charge_detect_filtered) |-> $past(charge_detect_raw);
   endproperty
   a_filter_rise: assert property (p_filter_rise) else $error("filter rose without input");
   property p_filter_fall;
      $fell(charge_detect_filtered) |-> !$past(charge_detect_raw) || $past(wr) || $past(wr, 2) || $past(wr, 3);
   endproperty
   a_filter_fall: assert property (p_filter_fall) else $error("filter fell without cause");
   property p_recover_cause;
      recovery_pulse |-> $past(rcv_cmd) || $past(rcv_cmd, 2);
   endproperty
   a_recover_cause: assert property (p_recover_cause) else $error("recovery without command");
   property p_recover_single;
      recovery_pulse |=> !recovery_pulse;
   endproperty
   a_recover_single: assert property (p_recover_single) else $error("recovery pulse too long");
   property p_irq_cause;
      $rose(irq) |-> $past(|fault_detect_a, 2) || $past(|fault_detect_a) || $past(wr) || $past(wr, 2);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("interrupt without event");
endmodule : prot_switch_checker

bind protection_switch_config prot_switch_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .fault_detect_a, .charge_detect_raw, .charge_detect_filtered, .recovery_pulse, .irq);

// file: host_apb_model.sv
// apb host model issuing register transfers
`timescale 1ns/1ps
module host_apb_model (
   // clock and answer
   input wire logic pclk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // request held until ready is seen; released lines show garbage, not stale values
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : host_apb_model

// file: test_protection_switch_config.sv
// self-checking testbench of the protection switch block
`timescale 1ns/1ps
module test_protection_switch_config;
   import prot_switch_pkg::*;
   // ====
   // signals
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic current_low, locked_security_state, charge_detect_raw, charge_detect_filtered, recovery_pulse;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] fault_detect_a;
   switch_pair_t body_diode_current, fault_switch_off, switch_drive;
   int mismatches = 0;
   int compares = 0;
   int pulses = 0;
   // short debounce step keeps the run brief
   protection_switch_config #(.STEP_CYCLES(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .current_low, .body_diode_current, .fault_detect_a, .fault_switch_off,
      .locked_security_state, .charge_detect_raw, .switch_drive, .charge_detect_filtered, .recovery_pulse, .irq);
   host_apb_model host (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
   always #50 pclk = ~pclk;
   always @(posedge pclk) if (recovery_pulse === 1'b1) pulses++;
   // ====
   // helpers
   task finish_test;
      if (mismatches == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      host.xfer(1'b1, a, d, r, e);
   endtask : wr
   task rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFFFFFF);
      logic [31:0] r;
      logic e;
      host.xfer(1'b0, a, 32'h0, r, e);
      check(r & m, exp);
   endtask : rd
   task settle(input int n);
      repeat (n) @(negedge pclk);
   endtask : settle
   // ====
   // scenarios
   task t_reset_bus;
      logic [31:0] r;
      logic e;
      rd(12'h000, 32'h18);
      rd(12'h004, 32'h01);
      rd(12'h008, 32'hA1);
      rd(12'h010, 32'h0, 32'h04);
      check(switch_drive, 2'b00);
      host.xfer(1'b0, 12'h020, 32'h0, r, e);
      check({31'h0, e}, 32'h1);
      check(r, 32'h0);
      wr(12'h000, 32'h0);
      rd(12'h000, 32'h18);
   endtask : t_reset_bus
   task t_edit_auto;
      wr(12'h00C, 32'h7);
      wr(12'h000, 32'h9C);
      wr(12'h00C, 32'h8);
      rd(12'h000, 32'h9C);
      rd(12'h010, 32'h04, 32'h0C);
      check(switch_drive, 2'b11);
      @(posedge pclk);
      current_low <= 1'b1;
      wr(12'h00C, 32'h3);
      settle(2);
      check(switch_drive, 2'b11);
      @(posedge pclk);
      current_low <= 1'b0;
      wr(12'h00C, 32'h1);
      settle(2);
      check(switch_drive, 2'b00);
      rd(12'h010, 32'h0, 32'h04);
   endtask : t_edit_auto
   task t_test_mode;
      logic [3:0] cmds [4] = '{4'h3, 4'h2, 4'h5, 4'h4};
      logic [1:0] exps [4] = '{2'b10, 2'b00, 2'b01, 2'b00};
      for (int i = 0; i < 4; i++) begin
         wr(12'h00C, {28'h0, cmds[i]});
         settle(2);
         check(switch_drive, exps[i]);
      end
      @(posedge pclk);
      body_diode_current <= 2'b01;
      settle(3);
      check(switch_drive, 2'b01);
      @(posedge pclk);
      body_diode_current <= 2'b00;
      wr(12'h00C, 32'h4);
   endtask : t_test_mode
   task t_detect;
      @(posedge pclk);
      charge_detect_raw <= 1'b1;
      settle(2);
      check(charge_detect_filtered, 1'b0);
      settle(6);
      check(charge_detect_filtered, 1'b1);
      @(posedge pclk);
      charge_detect_raw <= 1'b0;
      settle(2);
      check(charge_detect_filtered, 1'b1);
      settle(8);
      check(charge_detect_filtered, 1'b0);
   endtask : t_detect
   task t_safety;
      @(posedge pclk);
      fault_detect_a <= 8'h40;
      settle(3);
      rd(12'h014, 32'h0);
      @(posedge pclk);
      fault_detect_a <= 8'h80;
      settle(3);
      rd(12'h014, 32'h80);
      rd(12'h018, 32'h1, 32'h1);
      check(irq, 1'b0);
      wr(12'h01C, 32'h1);
      settle(2);
      check(irq, 1'b1);
      @(posedge pclk);
      fault_detect_a <= 8'h00;
      wr(12'h018, 32'h1);
      settle(2);
      check(irq, 1'b0);
   endtask : t_safety
   task t_recover_parallel;
      @(posedge pclk);
      locked_security_state <= 1'b1;
      wr(12'h00C, 32'h6);
      settle(2);
      check(pulses, 0);
      rd(12'h014, 32'h80);
      rd(12'h018, 32'h2, 32'h2);
      wr(12'h00C, 32'h7);
      wr(12'h000, 32'h81);
      wr(12'h004, 32'h0);
      wr(12'h00C, 32'h8);
      wr(12'h00C, 32'h6);
      settle(2);
      check(pulses, 1);
      rd(12'h014, 32'h0);
      @(posedge pclk);
      body_diode_current <= 2'b01;
      charge_detect_raw <= 1'b1;
      settle(3);
      check(switch_drive, 2'b00);
      check(charge_detect_filtered, 1'b1);
      wr(12'h00C, 32'h7);
      wr(12'h000, 32'h01);
      settle(3);
      check(charge_detect_filtered, 1'b0);
   endtask : t_recover_parallel
   // ====
   // main sequence and watchdog
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      current_low = 1'b0;
      body_diode_current = 2'b00;
      fault_detect_a = 8'h00;
      fault_switch_off = 2'b00;
      locked_security_state = 1'b0;
      charge_detect_raw = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_bus;
      t_edit_auto;
      t_test_mode;
      t_detect;
      t_safety;
      t_recover_parallel;
      finish_test;
   end
   initial begin
      #1000000;
      mismatches++;
      finish_test;
   end
endmodule : test_protection_switch_config
